//--- src/ossdpm_pkg.sv
// Operation
// - A low pulse of 150 us to 1 ms width that comes at least 100 ms after the last one is ignored.
// - A pulse that breaks the width or spacing limits counts as a real demand and drives the safe state.
// - Five seconds with no test pulse on a monitored input raise the input failure state.
// - Pulses on different inputs that overlap three times in a row raise the input failure state; in the code an accepted pulse with no overlap clears the count.
// - The failure state is reached within 2 ms of the failure condition.
// - Each active output is switched off for a test pulse of 450 to 550 us.
// - Output test pulses repeat every 810 to 990 ms.
// - At most one output carries a test pulse at any moment.
// - Each single output follows its source select, where 0xFF is always on and 0x00 always off.
// - An enabled pair drives two outputs together from the pair source; pairing is off by default.
// - A configured output carries the inverse of the safe fieldbus error bit.
// - Outputs source current while active and go off to show a fault or trip a device.
// - In dual input mode the two inputs of a pair that disagree for over 100 ms raise a fault.
package ossdpm_pkg;
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned PW_MIN_US = 150;
    localparam int unsigned PW_MAX_US = 1000;
    localparam int unsigned PI_MIN_MS = 100;
    localparam int unsigned NOPULSE_MS = 5000;
    localparam int unsigned DUAL_MS = 100;
    localparam int unsigned OUT_PW_US = 500;
    localparam int unsigned OUT_PI_MS = 900;
    localparam int unsigned OVERLAP_LIMIT = 3;
    localparam int unsigned PW_MIN_CYC = (PW_MIN_US * (CLK_HZ / 1_000_000));
    localparam int unsigned PW_MAX_CYC = (PW_MAX_US * (CLK_HZ / 1_000_000));
    localparam int unsigned PI_MIN_CYC = (PI_MIN_MS * (CLK_HZ / 1000));
    localparam longint unsigned NOPULSE_CYC = (64'(NOPULSE_MS) * (CLK_HZ / 1000));
    localparam int unsigned DUAL_CYC = (DUAL_MS * (CLK_HZ / 1000));
    localparam int unsigned OUT_PW_CYC = (OUT_PW_US * (CLK_HZ / 1_000_000));
    localparam int unsigned OUT_PI_CYC = (OUT_PI_MS * (CLK_HZ / 1000));
    localparam logic [7:0] SRC_ON = 8'hFF;
    localparam logic [7:0] SRC_OFF = 8'h00;
    localparam logic [7:0] SRC_FB_ERR = 8'hFE;
    localparam logic RESET_PAIR_EN = 1'b0;
endpackage

//--- src/ossdpm_chan_if.sv
`timescale 1ns/100ps
interface ossdpm_chan_if;
    logic in_sync;
    logic pulse_ok;
    logic low_now;
    logic demand;
    logic stale;
    modport mon(input in_sync, output pulse_ok, output low_now, output demand, output stale);
    modport top(output in_sync, input pulse_ok, input low_now, input demand, input stale);
endinterface

//--- src/ossdpm_chan_mon.sv
`timescale 1ns/100ps
module ossdpm_chan_mon #(
    parameter int unsigned PW_MIN = 37500,
    parameter int unsigned PW_MAX = 250000,
    parameter int unsigned PI_MIN = 25000000,
    parameter int unsigned NOPULSE = 1250000000
) (
    input wire logic sys_clk,
    input wire logic srst,
    ossdpm_chan_if.mon ch
);
    logic [31:0] low_cnt_q;
    logic [31:0] since_q;
    logic prev_q;
    logic seen_q;
    logic demand_q;
    logic ok_q;
    wire logic rise = ch.in_sync && !prev_q;

    // Width of the current low interval.
    always_ff @(posedge sys_clk) begin
        if (srst || ch.in_sync) begin
            low_cnt_q <= 32'h0000_0000;
        end else if (low_cnt_q != 32'hFFFF_FFFF) begin
            low_cnt_q <= low_cnt_q + 32'h0000_0001;
        end
    end

    // Time since the end of the last accepted pulse.
    always_ff @(posedge sys_clk) begin
        if (srst || (rise && ok_q)) begin
            since_q <= 32'h0000_0000;
        end else if (since_q != 32'hFFFF_FFFF) begin
            since_q <= since_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prev_q <= 1'b1;
        end else begin
            prev_q <= ch.in_sync;
        end
    end

    // A low is a demand once it outlasts the pulse window.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            demand_q <= 1'b0;
        end else if (!ch.in_sync && low_cnt_q >= PW_MAX) begin
            demand_q <= 1'b1;
        end else if (rise) begin
            demand_q <= !((low_cnt_q >= PW_MIN) && (!seen_q || since_q >= PI_MIN));
        end else if (ch.in_sync && demand_q && low_cnt_q == 32'h0000_0000) begin
            demand_q <= demand_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ok_q <= 1'b0;
        end else begin
            ok_q <= !ch.in_sync && (low_cnt_q + 32'h0000_0001 >= PW_MIN)
                && (low_cnt_q < PW_MAX) && (!seen_q || since_q >= PI_MIN);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            seen_q <= 1'b0;
        end else if (rise && ok_q) begin
            seen_q <= 1'b1;
        end
    end

    assign ch.pulse_ok = rise && ok_q;
    assign ch.low_now = !ch.in_sync;
    assign ch.demand = demand_q;
    assign ch.stale = (since_q >= NOPULSE);
endmodule // ossdpm_chan_mon

//--- src/ossdpm_top.sv
`timescale 1ns/100ps
module ossdpm_top
    import ossdpm_pkg::*;
#(
    parameter int unsigned NOPULSE_CYCLES = 32'(ossdpm_pkg::NOPULSE_CYC),
    parameter int unsigned PI_MIN_CYCLES = ossdpm_pkg::PI_MIN_CYC,
    parameter int unsigned DUAL_CYCLES = ossdpm_pkg::DUAL_CYC,
    parameter int unsigned OUT_PI_CYCLES = ossdpm_pkg::OUT_PI_CYC
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [3:0] safe_input,
    input wire logic [3:0] input_monitor_enable,
    input wire logic [1:0] input_pair_enable,
    input wire logic [1:0] output_pair_enable,
    input wire logic [15:0] output_pair_source_select,
    input wire logic [31:0] single_output_source_select,
    input wire logic [255:0] safety_state,
    input wire logic fieldbus_error,
    input wire logic failure_ack,
    output logic [3:0] safe_demand,
    output logic input_failure,
    output logic [1:0] pair_mismatch,
    output logic [3:0] safe_output,
    output logic [3:0] output_testing
);
    import ossdpm_pkg::*;

    typedef enum logic [1:0] {OT_WAIT, OT_PULSE, OT_GAP} ossdpm_ot_type;

    logic [3:0] s1_q;
    logic [3:0] s2_q;
    logic [3:0] low_v;
    logic [3:0] ok_v;
    logic [3:0] dem_v;
    logic [3:0] stale_v;
    logic [1:0] ovl_cnt_q;
    logic ovl_prev_q;
    logic [1:0][31:0] dual_cnt_q;
    logic [3:0] level_d;
    logic [31:0] ot_cnt_q;
    logic [1:0] ot_ch_q;
    ossdpm_ot_type ot_q;
    wire logic ovl_now = ($countones(low_v & input_monitor_enable) > 1);

    // Two flip-flops on every safe_input pin before any logic.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s1_q <= 4'hF;
            s2_q <= 4'hF;
        end else begin
            s1_q <= safe_input;
            s2_q <= s1_q;
        end
    end

    for (genvar i = 0; i < 4; i++) begin : g_ch
        ossdpm_chan_if cif ();
        assign cif.in_sync = s2_q[i];
        ossdpm_chan_mon #(
            .PW_MIN(PW_MIN_CYC),
            .PW_MAX(PW_MAX_CYC),
            .PI_MIN(PI_MIN_CYCLES),
            .NOPULSE(NOPULSE_CYCLES)
        ) u_mon (
            .sys_clk(sys_clk),
            .srst(srst),
            .ch(cif.mon)
        );
        assign low_v[i] = cif.low_now;
        assign ok_v[i] = cif.pulse_ok;
        assign dem_v[i] = cif.demand;
        assign stale_v[i] = cif.stale;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            safe_demand <= 4'h0;
        end else begin
            safe_demand <= dem_v & input_monitor_enable;
        end
    end

    // Counts overlap episodes; a clean accepted pulse restarts the run.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ovl_cnt_q <= 2'd0;
            ovl_prev_q <= 1'b0;
        end else begin
            ovl_prev_q <= ovl_now;
            if (ovl_now && !ovl_prev_q) begin
                if (ovl_cnt_q != 2'(OVERLAP_LIMIT)) begin
                    ovl_cnt_q <= ovl_cnt_q + 2'd1;
                end
            end else if (!ovl_now && |(ok_v & input_monitor_enable)) begin
                ovl_cnt_q <= 2'd0;
            end
        end
    end

    // Failure is set within a few cycles of its cause and held until acknowledged after every cause has gone; a standing cause wins over failure_ack.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            input_failure <= 1'b0;
        end else if (|(stale_v & input_monitor_enable) || ovl_cnt_q == 2'(OVERLAP_LIMIT)
                || |pair_mismatch) begin
            input_failure <= 1'b1;
        end else if (failure_ack) begin
            input_failure <= 1'b0;
        end
    end

    for (genvar p = 0; p < 2; p++) begin : g_dual
        always_ff @(posedge sys_clk) begin
            if (srst || !input_pair_enable[p] || (s2_q[2*p] == s2_q[2*p+1])) begin
                dual_cnt_q[p] <= 32'h0000_0000;
                pair_mismatch[p] <= 1'b0;
            end else begin
                if (dual_cnt_q[p] != 32'hFFFF_FFFF) begin
                    dual_cnt_q[p] <= dual_cnt_q[p] + 32'h0000_0001;
                end
                pair_mismatch[p] <= (dual_cnt_q[p] >= DUAL_CYCLES);
            end
        end
    end

    // Output level from the selected source, pairs taking precedence.
    always_comb begin
        level_d = 4'h0;
        for (int k = 0; k < 4; k++) begin
            logic [7:0] sel;
            sel = output_pair_enable[k/2] ? output_pair_source_select[(k/2)*8 +: 8]
                : single_output_source_select[k*8 +: 8];
            if (sel == SRC_ON) begin
                level_d[k] = 1'b1;
            end else if (sel == SRC_OFF) begin
                level_d[k] = 1'b0;
            end else if (sel == SRC_FB_ERR) begin
                level_d[k] = !fieldbus_error;
            end else begin
                level_d[k] = safety_state[sel];
            end
        end
    end

    // One test pulse at a time, round robin over the four outputs.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ot_q <= OT_WAIT;
            ot_cnt_q <= 32'h0000_0000;
            ot_ch_q <= 2'd0;
        end else begin
            case (ot_q)
                OT_WAIT: begin
                    if (ot_cnt_q >= (OUT_PI_CYCLES / 4) - OUT_PW_CYC) begin
                        ot_q <= OT_PULSE;
                        ot_cnt_q <= 32'h0000_0000;
                    end else begin
                        ot_cnt_q <= ot_cnt_q + 32'h0000_0001;
                    end
                end
                OT_PULSE: begin
                    if (ot_cnt_q >= OUT_PW_CYC - 1) begin
                        ot_q <= OT_GAP;
                        ot_cnt_q <= 32'h0000_0000;
                    end else begin
                        ot_cnt_q <= ot_cnt_q + 32'h0000_0001;
                    end
                end
                OT_GAP: begin
                    ot_q <= OT_WAIT;
                    ot_ch_q <= ot_ch_q + 2'd1;
                end
                default: begin
                    ot_q <= OT_WAIT;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            safe_output <= 4'h0;
            output_testing <= 4'h0;
        end else begin
            for (int k = 0; k < 4; k++) begin
                output_testing[k] <= (ot_q == OT_PULSE) && (ot_ch_q == 2'(k));
                safe_output[k] <= level_d[k] && !((ot_q == OT_PULSE) && (ot_ch_q == 2'(k)));
            end
        end
    end
endmodule // ossdpm_top

//--- sim/ossdpm_props.sv
`timescale 1ns/100ps
module ossdpm_props (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [1:0] output_pair_enable,
    input wire logic [15:0] output_pair_source_select,
    input wire logic [31:0] single_output_source_select,
    input wire logic fieldbus_error,
    input wire logic [3:0] safe_output,
    input wire logic [3:0] output_testing
);
    import ossdpm_pkg::*;
    // Length of the current run of output test cycles.
    logic [17:0] test_len_q;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            test_len_q <= 18'h00000;
        end else begin
            test_len_q <= (|output_testing) ? test_len_q + 18'h00001 : 18'h00000;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    AST_ONE_TEST: assert property ($onehot0(output_testing))
        else $error("Two outputs tested at once.");
    AST_TEST_OFF: assert property ((output_testing & safe_output) == 4'h0)
        else $error("Output on during its test.");
    AST_TEST_MAX: assert property (test_len_q <= 18'h2191C)
        else $error("Output test too long.");
    AST_TEST_MIN: assert property ($fell(|output_testing) |-> test_len_q >= 18'h1B774)
        else $error("Output test too short.");
    AST_SRC_ON: assert property (
        (!output_pair_enable[0] && single_output_source_select[7:0] == SRC_ON) [*3]
        |-> safe_output[0] || output_testing[0]) else $error("Output not on.");
    AST_SRC_OFF: assert property (
        (!output_pair_enable[0] && single_output_source_select[7:0] == SRC_OFF) [*3]
        |-> !safe_output[0]) else $error("Output not off.");
    AST_FB_ERR: assert property (
        (!output_pair_enable[0] && single_output_source_select[7:0] == SRC_FB_ERR
        && fieldbus_error) [*3] |-> !safe_output[0]) else $error("Output on with error.");
    AST_PAIR_OFF: assert property (
        (output_pair_enable[1] && output_pair_source_select[15:8] == SRC_OFF) [*3]
        |-> safe_output[3:2] == 2'h0) else $error("Pair not off.");
endmodule // ossdpm_props

bind ossdpm_top ossdpm_props props_u (.sys_clk, .srst, .output_pair_enable,
    .output_pair_source_select, .single_output_source_select, .fieldbus_error,
    .safe_output, .output_testing);

//--- sim/ossdpm_ctrl_model.sv
`timescale 1ns/100ps
module ossdpm_ctrl_model (
    input wire logic sys_clk,
    output logic [3:0] line
);
    initial line = 4'hF;
    // The lines idle high; a test drops the chosen lines low. Output tests are not watched.
    task automatic pulse(input logic [3:0] mask, input int unsigned width);
        @(negedge sys_clk);
        line = line & ~mask;
        repeat (width) @(negedge sys_clk);
        line = line | mask;
    endtask
endmodule // ossdpm_ctrl_model

//--- sim/ossd_pulse_monitor_and_output_tester_bench.sv
`timescale 1ns/100ps
module ossd_pulse_monitor_and_output_tester_bench;
    import ossdpm_pkg::*;
    localparam int unsigned NOPULSE = 45000;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic fieldbus_error = 1'b0;
    logic failure_ack = 1'b0;
    logic [3:0] safe_input;
    logic [3:0] input_monitor_enable = 4'h0;
    logic [1:0] input_pair_enable = 2'h0;
    logic [1:0] output_pair_enable = 2'h0;
    logic [15:0] output_pair_source_select = 16'h0000;
    logic [31:0] single_output_source_select = 32'h00000000;
    logic [255:0] safety_state = 256'h0;
    logic [3:0] safe_demand;
    logic input_failure;
    logic [1:0] pair_mismatch;
    logic [3:0] safe_output;
    logic [3:0] output_testing;
    int miscompares = 0;
    int checked = 0;
    ossdpm_top #(.NOPULSE_CYCLES(NOPULSE), .PI_MIN_CYCLES(200), .DUAL_CYCLES(100),
        .OUT_PI_CYCLES(500008)) dut_u (.sys_clk, .srst, .safe_input, .input_monitor_enable,
        .input_pair_enable, .output_pair_enable, .output_pair_source_select,
        .single_output_source_select, .safety_state, .fieldbus_error, .failure_ack,
        .safe_demand, .input_failure, .pair_mismatch, .safe_output, .output_testing);
    ossdpm_ctrl_model ctrl_u (.sys_clk, .line(safe_input));
    initial forever #2 sys_clk = ~sys_clk;
    task automatic wrap_up;
        if (miscompares == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %b expected %b", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int unsigned n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic rst(input logic [3:0] mon);
        srst = 1'b1;
        input_monitor_enable = mon;
        cyc(8);
        srst = 1'b0;
    endtask
    task automatic wait_fail(input int unsigned n);
        int unsigned i;
        i = 0;
        while (input_failure !== 1'b1 && i < n) begin
            cyc(1);
            i++;
        end
        if (input_failure !== 1'b1) begin
            miscompares++;
            wrap_up();
        end
    endtask
    function automatic logic lvl(input logic [7:0] code);
        if (code == SRC_ON) return 1'b1;
        if (code == SRC_OFF) return 1'b0;
        if (code == SRC_FB_ERR) return !fieldbus_error;
        return safety_state[code];
    endfunction
    function automatic logic [3:0] exp_out();
        logic [3:0] e;
        for (int i = 0; i < 4; i++) begin
            e[i] = output_pair_enable[i/2] ? lvl(output_pair_source_select[8*(i/2)+:8])
                : lvl(single_output_source_select[8*i+:8]);
        end
        return e;
    endfunction
    function automatic logic [7:0] pick();
        case ($urandom % 4)
            0: return SRC_ON;
            1: return SRC_OFF;
            2: return SRC_FB_ERR;
            default: return 8'($urandom_range(253, 1));
        endcase
    endfunction
    initial begin
        void'($urandom(46986));
        rst(4'h0);
        chk(safe_output, 4'h0);
        for (int k = 0; k < 15; k++) begin
            for (int i = 0; i < 4; i++) begin
                single_output_source_select[8*i+:8] = pick();
            end
            output_pair_source_select = {pick(), pick()};
            output_pair_enable = 2'($urandom);
            safety_state = {8{$urandom}};
            fieldbus_error = 1'($urandom);
            if (k > 11) begin
                output_pair_enable = 2'b10;
                output_pair_source_select[15:8] = SRC_OFF;
                fieldbus_error = 1'b1;
                single_output_source_select[7:0] = (k == 12) ? SRC_ON : SRC_FB_ERR;
            end
            cyc(4);
            // Output 0 holds the first test slot for this whole stretch after reset.
            chk(output_testing, 4'h1);
            chk(safe_output, exp_out() & 4'hE);
        end
        input_pair_enable = 2'b01;
        fork
            ctrl_u.pulse(4'h2, 150);
            begin
                cyc(60);
                chk({2'b00, pair_mismatch}, 4'h0);
                cyc(80);
                chk({2'b00, pair_mismatch}, 4'h1);
            end
        join
        chk({3'b000, input_failure}, 4'h1);
        failure_ack = 1'b1;
        cyc(5);
        chk({3'b000, input_failure}, 4'h0);
        failure_ack = 1'b0;
        input_pair_enable = 2'b00;
        rst(4'hC);
        repeat (2) begin
            ctrl_u.pulse(4'hC, 100);
            cyc(300);
        end
        chk({3'b000, input_failure}, 4'h0);
        ctrl_u.pulse(4'hC, 100);
        wait_fail(500);
        chk({3'b000, input_failure}, 4'h1);
        chk(safe_demand, 4'hC);
        // The overlap run still stands, so an acknowledge must not clear the failure.
        failure_ack = 1'b1;
        cyc(3);
        chk({3'b000, input_failure}, 4'h1);
        failure_ack = 1'b0;
        rst(4'h2);
        ctrl_u.pulse(4'h2, 38000);
        cyc(10);
        chk(safe_demand, 4'h0);
        cyc(300);
        ctrl_u.pulse(4'h2, 100);
        cyc(10);
        chk(safe_demand, 4'h2);
        rst(4'h1);
        cyc(NOPULSE - 1000);
        chk({3'b000, input_failure}, 4'h0);
        wait_fail(3000);
        chk({3'b000, input_failure}, 4'h1);
        wrap_up();
    end
endmodule // ossd_pulse_monitor_and_output_tester_bench
